// [src/mesc_top.sv]
// Ethernet MAC error statistics counters with Avalon-MM register access
`timescale 1ns/1ps
`default_nettype none
`include "mesc_cfg.svh"

// Functional notes
// - Count collisions only after 512 bit times
// - Counters are 16 bits and saturate
// - Any write to a counter clears it
// - Upper sixteen bits read zero
// - Count carrier drops during transmission
// - Count carrier absent during preamble
// - Count transmit attempts under four bytes
// - Count received frames failing CRC
// - Accept-bad-CRC mode stops CRC counting
// - Count receive-error assertions during reception
module mesc_top #(
  parameter int CNT_W = `MESC_CNT_W,
  parameter int LEN_W = `MESC_LEN_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [`MESC_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [`MESC_DATA_W-1:0] avs_writedata_in,
  output logic [`MESC_DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic mii_tx_clk_in,
  input wire logic mii_crs_in,
  input wire logic mii_col_in,
  input wire logic mii_rx_dv_in,
  input wire logic mii_rx_er_in,
  input wire logic tx_active_in,
  input wire logic tx_preamble_in,
  input wire logic tx_req_in,
  input wire logic [LEN_W-1:0] tx_len_in,
  input wire logic rx_crc_bad_in,
  output logic irq_out
);

  // Pin synchronisers and edge history
  logic [`MESC_PIN_W-1:0] pins;
  logic [`MESC_PIN_W-1:0] sync1_r;
  logic [`MESC_PIN_W-1:0] sync1_nxt;
  logic [`MESC_PIN_W-1:0] sync2_r;
  logic [`MESC_PIN_W-1:0] sync2_nxt;
  logic [`MESC_PIN_W-1:0] prev_r;
  logic [`MESC_PIN_W-1:0] prev_nxt;
  logic tx_clk_rise;
  logic crs_s;
  logic crs_fall;
  logic col_rise;
  logic rx_dv_s;
  logic rx_er_rise;

  assign pins = {mii_tx_clk_in, mii_crs_in, mii_col_in,
                 mii_rx_dv_in, mii_rx_er_in};

  always_comb begin
    sync1_nxt = pins;
    sync2_nxt = sync1_r;
    prev_nxt = sync2_r;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_r <= `MESC_PIN_RESET;
      sync2_r <= `MESC_PIN_RESET;
      prev_r <= `MESC_PIN_RESET;
    end else if (ce_in) begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign tx_clk_rise = sync2_r[`MESC_PIN_TXCLK] & ~prev_r[`MESC_PIN_TXCLK];
  assign crs_s = sync2_r[`MESC_PIN_CRS];
  assign crs_fall = ~sync2_r[`MESC_PIN_CRS] & prev_r[`MESC_PIN_CRS];
  assign col_rise = sync2_r[`MESC_PIN_COL] & ~prev_r[`MESC_PIN_COL];
  assign rx_dv_s = sync2_r[`MESC_PIN_RXDV];
  assign rx_er_rise = sync2_r[`MESC_PIN_RXER] & ~prev_r[`MESC_PIN_RXER];

  // Transmit bit-time tracking: one nibble per rising link clock edge
  logic [`MESC_BITCNT_W-1:0] bitcnt_r;
  logic [`MESC_BITCNT_W-1:0] bitcnt_nxt;
  logic late_window;
  logic nocarr_done_r;
  logic nocarr_done_nxt;

  assign late_window = (bitcnt_r >= `MESC_COL_WINDOW_BITS);

  always_comb begin
    bitcnt_nxt = bitcnt_r;
    nocarr_done_nxt = nocarr_done_r;
    if (!tx_active_in) begin
      bitcnt_nxt = `MESC_BITCNT_RESET;
      nocarr_done_nxt = 1'b0;
    end else begin
      // Stop at the window edge so the count cannot wrap
      if (tx_clk_rise && !late_window) begin
        bitcnt_nxt = bitcnt_r + `MESC_NIBBLE_BITS;
      end
      if (tx_preamble_in && !crs_s) begin
        nocarr_done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bitcnt_r <= `MESC_BITCNT_RESET;
      nocarr_done_r <= 1'b0;
    end else if (ce_in) begin
      bitcnt_r <= bitcnt_nxt;
      nocarr_done_r <= nocarr_done_nxt;
    end
  end

  // Register bus state
  mesc_pkg::mesc_bus_e state_r;
  mesc_pkg::mesc_bus_e state_nxt;
  logic waitrequest_r;
  logic waitrequest_nxt;
  mesc_pkg::mesc_word_t readdata_r;
  mesc_pkg::mesc_word_t readdata_nxt;
  mesc_pkg::mesc_word_t rd_mux;
  logic wr_take;
  logic mode_accept_r;
  logic mode_accept_nxt;
  mesc_pkg::mesc_evt_t stat_r;
  mesc_pkg::mesc_evt_t stat_nxt;
  mesc_pkg::mesc_evt_t mask_r;
  mesc_pkg::mesc_evt_t mask_nxt;
  mesc_pkg::mesc_evt_t w1c;
  mesc_pkg::mesc_evt_t clr;
  mesc_pkg::mesc_evt_t ev;
  logic irq_r;
  logic irq_nxt;
  logic [CNT_W-1:0] count [`MESC_NUM_CNT];

  // Event qualification
  always_comb begin
    ev = `MESC_EVT_RESET;
    ev[`MESC_EV_COL] = col_rise & tx_active_in & late_window;
    ev[`MESC_EV_LOST] = crs_fall & tx_active_in;
    // Once per frame, however long carrier stays away
    ev[`MESC_EV_NOCARR] = tx_active_in & tx_preamble_in & ~crs_s
                          & ~nocarr_done_r;
    ev[`MESC_EV_SHORT] = tx_req_in
                         & (tx_len_in < `MESC_SHORT_LEN);
    ev[`MESC_EV_CRC] = rx_crc_bad_in & ~mode_accept_r;
    ev[`MESC_EV_RXER] = rx_er_rise & rx_dv_s;
  end

  // The counters themselves
  mesc_cnt_if #(.WIDTH(CNT_W)) cnt_if [`MESC_NUM_CNT] ();

  genvar g;
  generate
    for (g = 0; g < `MESC_NUM_CNT; g++) begin : g_cnt
      assign cnt_if[g].inc = ev[g];
      assign cnt_if[g].clr = clr[g];
      assign count[g] = cnt_if[g].count;
      mesc_sat_counter #(.WIDTH(CNT_W)) u_cnt (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .cnt(cnt_if[g])
      );
    end
  endgenerate

  // Write is taken on the edge where waitrequest is seen low
  assign wr_take = (state_r == mesc_pkg::mesc_bus_ack) && avs_write_in;

  always_comb begin
    clr = `MESC_EVT_RESET;
    w1c = `MESC_EVT_RESET;
    if (wr_take) begin
      case (avs_address_in)
        `MESC_OFF_COL: clr[`MESC_EV_COL] = 1'b1;
        `MESC_OFF_LOST: clr[`MESC_EV_LOST] = 1'b1;
        `MESC_OFF_NOCARR: clr[`MESC_EV_NOCARR] = 1'b1;
        `MESC_OFF_SHORT: clr[`MESC_EV_SHORT] = 1'b1;
        `MESC_OFF_CRC: clr[`MESC_EV_CRC] = 1'b1;
        `MESC_OFF_RXER: clr[`MESC_EV_RXER] = 1'b1;
        `MESC_OFF_STAT: w1c = avs_writedata_in[`MESC_NUM_CNT-1:0];
        default: w1c = `MESC_EVT_RESET;
      endcase
    end
  end

  // Read data; everything above the field reads zero
  always_comb begin
    rd_mux = `MESC_REG_RESET;
    case (avs_address_in)
      `MESC_OFF_COL: rd_mux[CNT_W-1:0] = count[`MESC_EV_COL];
      `MESC_OFF_LOST: rd_mux[CNT_W-1:0] = count[`MESC_EV_LOST];
      `MESC_OFF_NOCARR: rd_mux[CNT_W-1:0] = count[`MESC_EV_NOCARR];
      `MESC_OFF_SHORT: rd_mux[CNT_W-1:0] = count[`MESC_EV_SHORT];
      `MESC_OFF_CRC: rd_mux[CNT_W-1:0] = count[`MESC_EV_CRC];
      `MESC_OFF_RXER: rd_mux[CNT_W-1:0] = count[`MESC_EV_RXER];
      `MESC_OFF_MODE: rd_mux[`MESC_MODE_ACCEPT_BAD] = mode_accept_r;
      `MESC_OFF_STAT: rd_mux[`MESC_NUM_CNT-1:0] = stat_r;
      `MESC_OFF_MASK: rd_mux[`MESC_NUM_CNT-1:0] = mask_r;
      default: rd_mux = `MESC_REG_RESET;
    endcase
  end

  // One wait cycle, then a single cycle with waitrequest low
  always_comb begin
    state_nxt = state_r;
    waitrequest_nxt = waitrequest_r;
    readdata_nxt = readdata_r;
    case (state_r)
      mesc_pkg::mesc_bus_idle: begin
        if (avs_read_in || avs_write_in) begin
          state_nxt = mesc_pkg::mesc_bus_ack;
          waitrequest_nxt = 1'b0;
          readdata_nxt = avs_read_in ? rd_mux : `MESC_REG_RESET;
        end
      end
      mesc_pkg::mesc_bus_ack: begin
        state_nxt = mesc_pkg::mesc_bus_idle;
        waitrequest_nxt = 1'b1;
      end
      default: begin
        state_nxt = mesc_pkg::mesc_bus_idle;
        waitrequest_nxt = 1'b1;
      end
    endcase
  end

  // Mode, sticky status and mask
  always_comb begin
    mode_accept_nxt = mode_accept_r;
    mask_nxt = mask_r;
    if (wr_take && (avs_address_in == `MESC_OFF_MODE)) begin
      mode_accept_nxt = avs_writedata_in[`MESC_MODE_ACCEPT_BAD];
    end
    if (wr_take && (avs_address_in == `MESC_OFF_MASK)) begin
      mask_nxt = avs_writedata_in[`MESC_NUM_CNT-1:0];
    end
    // A new event outweighs a simultaneous write-one-to-clear
    stat_nxt = (stat_r & ~w1c) | ev;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= mesc_pkg::mesc_bus_idle;
      waitrequest_r <= 1'b1;
      readdata_r <= `MESC_REG_RESET;
      mode_accept_r <= 1'b0;
      stat_r <= `MESC_EVT_RESET;
      mask_r <= `MESC_EVT_RESET;
      irq_r <= 1'b0;
    end else if (ce_in) begin
      state_r <= state_nxt;
      waitrequest_r <= waitrequest_nxt;
      readdata_r <= readdata_nxt;
      mode_accept_r <= mode_accept_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign avs_readdata_out = readdata_r;
  assign avs_waitrequest_out = waitrequest_r;
  assign irq_out = irq_r;

  AST_UPPER_ZERO: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !avs_waitrequest_out |-> avs_readdata_out[`MESC_DATA_W-1:CNT_W] == '0)
    else $error("Upper read bits not zero");

  AST_WAIT_ONE: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && (avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("Waitrequest did not pulse low for one cycle");

  AST_LATE_COL: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && col_rise && tx_active_in
    && (bitcnt_r >= `MESC_COL_WINDOW_BITS) && !clr[`MESC_EV_COL]
    && (count[`MESC_EV_COL] != '1)
    |=> count[`MESC_EV_COL] == $past(count[`MESC_EV_COL]) + 1'b1)
    else $error("Late collision not counted");

  AST_EARLY_COL: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (bitcnt_r < `MESC_COL_WINDOW_BITS) && !clr[`MESC_EV_COL]
    |=> $stable(count[`MESC_EV_COL]))
    else $error("Collision inside window was counted");

  AST_LOST_IDLE: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !tx_active_in && !clr[`MESC_EV_LOST]
    |=> $stable(count[`MESC_EV_LOST]))
    else $error("Lost carrier counted outside transmission");

  AST_NOCARR_ONCE: assert property (
    @(posedge clk_in) disable iff (rst_in)
    nocarr_done_r && tx_active_in && !clr[`MESC_EV_NOCARR]
    |=> $stable(count[`MESC_EV_NOCARR]))
    else $error("Missing carrier counted twice in one frame");

  AST_SHORT_LEGAL: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !(tx_req_in && (tx_len_in < `MESC_SHORT_LEN))
    && !clr[`MESC_EV_SHORT]
    |=> $stable(count[`MESC_EV_SHORT]))
    else $error("Legal length counted as short");

  AST_CRC_COUNT: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && rx_crc_bad_in && !mode_accept_r && !clr[`MESC_EV_CRC]
    && (count[`MESC_EV_CRC] != '1)
    |=> count[`MESC_EV_CRC] == $past(count[`MESC_EV_CRC]) + 1'b1)
    else $error("CRC error frame not counted");

  AST_CRC_ACCEPT: assert property (
    @(posedge clk_in) disable iff (rst_in)
    mode_accept_r && !clr[`MESC_EV_CRC]
    |=> $stable(count[`MESC_EV_CRC]))
    else $error("CRC counted while bad frames accepted");

  AST_RXER_COUNT: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && rx_er_rise && rx_dv_s && !clr[`MESC_EV_RXER]
    && (count[`MESC_EV_RXER] != '1)
    |=> count[`MESC_EV_RXER] == $past(count[`MESC_EV_RXER]) + 1'b1)
    else $error("Receive error not counted");

  AST_STAT_SET_WINS: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && ev[`MESC_EV_COL] |=> stat_r[`MESC_EV_COL] ##1 1'b1)
    else $error("Event lost against status clear");

endmodule : mesc_top
`default_nettype wire

// [include/mesc_cfg.svh]
// Register map, field positions and timing counts of the statistics block
`ifndef MESC_CFG_SVH
`define MESC_CFG_SVH

`define MESC_CNT_W 16
`define MESC_NUM_CNT 6
`define MESC_ADDR_W 8
`define MESC_DATA_W 32
`define MESC_LEN_W 12
`define MESC_BITCNT_W 10

`define MESC_OFF_COL 8'h00
`define MESC_OFF_LOST 8'h04
`define MESC_OFF_NOCARR 8'h08
`define MESC_OFF_SHORT 8'h0c
`define MESC_OFF_CRC 8'h10
`define MESC_OFF_RXER 8'h14
`define MESC_OFF_MODE 8'h18
`define MESC_OFF_STAT 8'h1c
`define MESC_OFF_MASK 8'h20

`define MESC_EV_COL 0
`define MESC_EV_LOST 1
`define MESC_EV_NOCARR 2
`define MESC_EV_SHORT 3
`define MESC_EV_CRC 4
`define MESC_EV_RXER 5

`define MESC_MODE_ACCEPT_BAD 0

`define MESC_REG_RESET 32'h0000_0000
`define MESC_EVT_RESET 6'h00
`define MESC_BITCNT_RESET 10'h000
`define MESC_COL_WINDOW_BITS 10'h200
`define MESC_NIBBLE_BITS 10'h004
`define MESC_SHORT_LEN 12'h004

`define MESC_PIN_W 5
`define MESC_PIN_TXCLK 4
`define MESC_PIN_CRS 3
`define MESC_PIN_COL 2
`define MESC_PIN_RXDV 1
`define MESC_PIN_RXER 0
`define MESC_PIN_RESET 5'h00

`endif

// [include/mesc_pkg.sv]
// Types shared by the statistics counter block
`include "mesc_cfg.svh"
package mesc_pkg;
  typedef enum logic {mesc_bus_idle, mesc_bus_ack} mesc_bus_e;
  typedef logic [`MESC_NUM_CNT-1:0] mesc_evt_t;
  typedef logic [`MESC_DATA_W-1:0] mesc_word_t;
endpackage : mesc_pkg

// [include/mesc_cnt_if.sv]
// Link between the register logic and one saturating counter
`timescale 1ns/1ps
`default_nettype none
`include "mesc_cfg.svh"
interface mesc_cnt_if #(parameter int WIDTH = `MESC_CNT_W) ();
  logic inc;
  logic clr;
  logic [WIDTH-1:0] count;
  modport ctrl (output inc, output clr, input count);
  modport counter (input inc, input clr, output count);
endinterface : mesc_cnt_if
`default_nettype wire

// [src/mesc_sat_counter.sv]
// One saturating event counter, cleared by software
`timescale 1ns/1ps
`default_nettype none
`include "mesc_cfg.svh"
module mesc_sat_counter #(
  parameter int WIDTH = `MESC_CNT_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  mesc_cnt_if.counter cnt
);
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  always_comb begin
    count_nxt = count_r;
    if (cnt.clr) begin
      // Clear beats a coincident event
      count_nxt = '0;
    end else if (cnt.inc && (count_r != '1)) begin
      count_nxt = count_r + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_r <= '0;
    end else if (ce_in) begin
      count_r <= count_nxt;
    end
  end

  assign cnt.count = count_r;

  AST_CNT_RESET_ZERO: assert property (
    @(posedge clk_in) rst_in |=> count_r == '0)
    else $error("Counter not zero after reset");

  AST_CNT_CLEAR: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && cnt.clr |=> count_r == '0)
    else $error("Write did not clear counter");

  AST_CNT_STEP_ONE: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ce_in && cnt.inc && !cnt.clr && (count_r != '1)
    |=> count_r == $past(count_r) + 1'b1)
    else $error("Counter did not step by one");

  AST_CNT_SATURATE: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !cnt.clr && (count_r == '1) |=> count_r == '1)
    else $error("Counter left all ones without clear");

  AST_CNT_HOLD: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !cnt.inc && !cnt.clr |=> $stable(count_r))
    else $error("Counter moved without event");
endmodule : mesc_sat_counter
`default_nettype wire

// [sim/mesc_phy_model.sv]
// Behavioural MII PHY: transmit clock and line status pins
`timescale 1ns/1ps
`default_nettype none
module mesc_phy_model (
  input wire logic run_in,
  input wire logic crs_in,
  input wire logic col_in,
  input wire logic rx_dv_in,
  input wire logic rx_er_in,
  output logic tx_clk_out,
  output logic crs_out,
  output logic col_out,
  output logic rx_dv_out,
  output logic rx_er_out
);
  // Transmit clock toggles only within frames, 400 ns period
  initial tx_clk_out = 1'b0;
  always #200 tx_clk_out = run_in ? ~tx_clk_out : 1'b0;
  assign crs_out = crs_in;
  assign col_out = col_in;
  assign rx_dv_out = rx_dv_in;
  assign rx_er_out = rx_er_in;
endmodule : mesc_phy_model
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the error statistics counters
`timescale 1ns/1ps
`default_nettype none
`include "mesc_cfg.svh"
module testbench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic [31:0] v;
  logic wait_req;
  logic irq;
  logic run = 1'b0, crs = 1'b0, col = 1'b0, dv = 1'b0, er = 1'b0;
  logic tx_clk, crs_p, col_p, dv_p, er_p;
  logic tx_act = 1'b0, pre = 1'b0, req = 1'b0, crc_bad = 1'b0;
  logic [`MESC_LEN_W-1:0] len = '0;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  always #25 clk_in = ~clk_in;

  mesc_phy_model i_phy (.run_in(run), .crs_in(crs), .col_in(col),
    .rx_dv_in(dv), .rx_er_in(er), .tx_clk_out(tx_clk), .crs_out(crs_p),
    .col_out(col_p), .rx_dv_out(dv_p), .rx_er_out(er_p));

  mesc_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wait_req), .mii_tx_clk_in(tx_clk),
    .mii_crs_in(crs_p), .mii_col_in(col_p), .mii_rx_dv_in(dv_p),
    .mii_rx_er_in(er_p), .tx_active_in(tx_act), .tx_preamble_in(pre),
    .tx_req_in(req), .tx_len_in(len), .rx_crc_bad_in(crc_bad),
    .irq_out(irq));

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    do @(posedge clk_in); while (wait_req !== 1'b0);
    v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    check(v, e);
  endtask : rchk

  task automatic crc_pulse();
    @(posedge clk_in);
    crc_bad <= 1'b1;
    @(posedge clk_in);
    crc_bad <= 1'b0;
  endtask : crc_pulse

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    tick(16);
    rst_in <= 1'b0;
    tick(2);
    for (int i = 0; i < 6; i++) begin
      rchk(8'(4 * i), '0);
    end
    rchk(8'h40, '0);
    // Lengths 0 to 3 are short, 4 and 5 are not
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_in);
      req <= 1'b1;
      len <= `MESC_LEN_W'(i);
      @(posedge clk_in);
      req <= 1'b0;
    end
    tick(2);
    rchk(`MESC_OFF_SHORT, 32'h4);
    crc_pulse();
    tick(2);
    rchk(`MESC_OFF_CRC, 32'h1);
    bus(1'b1, `MESC_OFF_MODE, 32'h1);
    rchk(`MESC_OFF_MODE, 32'h1);
    crc_pulse();
    tick(2);
    rchk(`MESC_OFF_CRC, 32'h1);
    bus(1'b1, `MESC_OFF_MODE, 32'h0);
    // Interrupt: crc unmasked, short left masked
    check(32'(irq), 32'h0);
    bus(1'b1, `MESC_OFF_MASK, 32'h10);
    rchk(`MESC_OFF_MASK, 32'h10);
    crc_pulse();
    tick(3);
    check(32'(irq), 32'h1);
    rchk(`MESC_OFF_STAT, 32'h18);
    bus(1'b1, `MESC_OFF_STAT, 32'h10);
    tick(2);
    check(32'(irq), 32'h0);
    // Clear lands on the same edge as an event
    fork
      bus(1'b1, `MESC_OFF_CRC, 32'h0000_ffff);
      begin
        tick(2);
        crc_bad <= 1'b1;
        tick(1);
        crc_bad <= 1'b0;
      end
    join
    rchk(`MESC_OFF_CRC, '0);
    // Receive errors: two inside a frame, one outside
    dv <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      tick(10);
      er <= 1'b1;
      tick(10);
      er <= 1'b0;
      if (i == 1)
        dv <= 1'b0;
    end
    tick(10);
    rchk(`MESC_OFF_RXER, 32'h2);
    // Frame with early and late collision, then carrier loss
    crs <= 1'b1;
    tick(10);
    run <= 1'b1;
    tx_act <= 1'b1;
    pre <= 1'b1;
    tick(128);
    pre <= 1'b0;
    col <= 1'b1;
    tick(16);
    col <= 1'b0;
    tick(1100);
    col <= 1'b1;
    tick(16);
    col <= 1'b0;
    tick(16);
    crs <= 1'b0;
    tick(16);
    tx_act <= 1'b0;
    run <= 1'b0;
    tick(16);
    // Frame whose preamble goes out with no carrier
    run <= 1'b1;
    tx_act <= 1'b1;
    pre <= 1'b1;
    tick(64);
    pre <= 1'b0;
    tick(32);
    tx_act <= 1'b0;
    run <= 1'b0;
    tick(16);
    rchk(`MESC_OFF_COL, 32'h1);
    rchk(`MESC_OFF_LOST, 32'h1);
    rchk(`MESC_OFF_NOCARR, 32'h1);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 8'(4 * i), 32'h0000_5a5a ^ i);
      rchk(8'(4 * i), '0);
    end
    // Saturation under back-to-back events
    crc_bad <= 1'b1;
    tick(65540);
    crc_bad <= 1'b0;
    tick(2);
    rchk(`MESC_OFF_CRC, 32'h0000_ffff);
    final_report();
  end
endmodule : testbench
`default_nettype wire
